// ### hw/pia_defines.svh
// constants of the pmic interrupt aggregator: addresses, fields, resets, timing
//
// Overview of operation
// - any unmasked pending factor pulls interrupt low
// - masked factors never pull interrupt low
// - interrupt held high 500 us after clearing
// - summary D0-D3 show groups one-four pending
// - summary D4 shows any self-test failure
// - self-test failure also sets its group bit
// - summary D3 shows output pin mismatch
// - summary D5 shows a reset-causing factor pending
// - summary clears only through clearing its factors
// - mismatch factors for five monitored output pins
// - latched current, short and voltage fault factors
// - latched backup, self-test, battery, temperature factors
// - writing one clears flag, zero leaves it
// - group fully cleared releases interrupt high
// - groups read-only at 04h-07h except writable dummy D7 at 07h, one means request
`ifndef PIA_DEFINES_SVH
`define PIA_DEFINES_SVH

// register addresses
`define PIA_ADDR_SUMMARY   6'h03
`define PIA_ADDR_GROUP1    6'h04
`define PIA_ADDR_GROUP4    6'h07
`define PIA_ADDR_CLEAR1    6'h08
`define PIA_ADDR_CLEAR4    6'h0B
`define PIA_ADDR_MASK1     6'h0C
`define PIA_ADDR_MASK4     6'h0F

// summary field positions
`define PIA_SUM_SELFTEST   4
`define PIA_SUM_RESET      5

// implemented bits per request group
`define PIA_VALID_GROUP1   8'hFF
`define PIA_VALID_GROUP2   8'h3F
`define PIA_VALID_GROUP3   8'hFF
`define PIA_VALID_GROUP4   8'h9F

// self-test bits of the misc group: backup, state machine, oscillator, reference
`define PIA_SELFTEST_MISC  8'h74
// dummy bit of the pin monitor group
`define PIA_DUMMY_BIT      7

// factors that lead to a device reset
`define PIA_RSTC_GROUP1    8'h10
`define PIA_RSTC_GROUP2    8'h30
`define PIA_RSTC_GROUP3    8'h20
`define PIA_RSTC_GROUP4    8'h00

// reset values
`define PIA_RST_PEND       8'h00
`define PIA_RST_MASK       8'h00

// timing
`define PIA_CLK_PERIOD_NS  100
`define PIA_HOLDOFF_US     500

`endif

// ### hw/pia_pkg.sv
// types of the pmic interrupt aggregator
package pia_pkg;

  // register port request
  typedef struct packed
  {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pia_bus_req_t;

  // complete state of the aggregator
  typedef struct packed
  {
    logic [3:0][7:0] pend;
    logic [3:0][7:0] mask;
    logic [1:0]      sd_grp;
    logic [3:0][4:0] cmd_pipe;
    logic [15:0]     hold_cnt;
    logic            irq_n;
    logic [7:0]      summary;
    logic [7:0]      rdata;
  } pia_state_t;

endpackage : pia_pkg

// ### hw/pia_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns

module pia_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // pin side
  input  wire logic [WIDTH-1:0] i_async,
  // filtered level
  output logic      [WIDTH-1:0] o_level
);

  typedef struct packed
  {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } pia_sync_state_t;

  pia_sync_state_t s_q;
  pia_sync_state_t s_d;

  // shift chain, level follows once stages two and three agree
  always_comb
  begin
    s_d     = s_q;
    s_d.s1  = i_async;
    s_d.s2  = s_q.s1;
    s_d.s3  = s_q.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (s_q.s2[i] == s_q.s3[i])
      begin
        s_d.lvl[i] = s_q.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.lvl;

endmodule : pia_sync

// ### hw/pia_top.sv
// interrupt aggregation of the power-management device
`timescale 1ns/1ns
`include "pia_defines.svh"

module pia_top #(
  parameter int HOLDOFF_CYC =
    (`PIA_HOLDOFF_US * 1000 + `PIA_CLK_PERIOD_NS - 1) / `PIA_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_nrst,
  // register port
  input  wire pia_pkg::pia_bus_req_t i_bus,
  output logic [7:0]                 o_rdata,
  // fault detector levels
  input  wire logic [7:0]            i_undervolt_det,
  input  wire logic [5:0]            i_overvolt_det,
  input  wire logic [7:0]            i_misc_det,
  input  wire logic [1:0]            i_selftest_grp,
  // digital output monitoring
  input  wire logic [4:0]            i_pin_cmd,
  input  wire logic [4:0]            i_pin_mon,
  // interrupt and status
  output logic                       o_irq_out_n,
  output logic [7:0]                 o_irq_source_summary
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_q;
  logic       rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [7:0] uv_lvl;
  logic [5:0] ov_lvl;
  logic [7:0] misc_lvl;
  logic [1:0] sd_lvl;
  logic [4:0] pin_lvl;

  pia_sync #(.WIDTH(8)) u_sync_uv (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_undervolt_det),
    .o_level (uv_lvl)
  );

  pia_sync #(.WIDTH(6)) u_sync_ov (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_overvolt_det),
    .o_level (ov_lvl)
  );

  pia_sync #(.WIDTH(8)) u_sync_misc (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_misc_det),
    .o_level (misc_lvl)
  );

  pia_sync #(.WIDTH(2)) u_sync_sd (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_selftest_grp),
    .o_level (sd_lvl)
  );

  pia_sync #(.WIDTH(5)) u_sync_pin (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_async (i_pin_mon),
    .o_level (pin_lvl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // constant tables

  localparam logic [3:0][7:0] VALID =
    {`PIA_VALID_GROUP4, `PIA_VALID_GROUP3, `PIA_VALID_GROUP2, `PIA_VALID_GROUP1};
  localparam logic [3:0][7:0] RSTC =
    {`PIA_RSTC_GROUP4, `PIA_RSTC_GROUP3, `PIA_RSTC_GROUP2, `PIA_RSTC_GROUP1};
  localparam logic [15:0] HOLD_LOAD = 16'(HOLDOFF_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  pia_pkg::pia_state_t s_q;
  pia_pkg::pia_state_t s_d;
  logic [3:0][7:0]     set_v;
  logic [3:0][7:0]     clr_v;
  logic [4:0]          mismatch;
  logic                clr_any;
  logic                active;

  // factor sets, clear strobes and interrupt decision
  always_comb
  begin
    s_d      = s_q;
    // commanded pin values delayed to meet the synchronised pin level
    s_d.cmd_pipe = {s_q.cmd_pipe[2:0], i_pin_cmd};
    mismatch = (s_q.cmd_pipe[3] == s_q.cmd_pipe[2]) ?
               (pin_lvl ^ s_q.cmd_pipe[3]) : 5'h00;
    set_v[0] = uv_lvl;
    set_v[1] = {2'h0, ov_lvl};
    set_v[2] = misc_lvl;
    set_v[3] = {3'h0, mismatch};
    clr_any  = 1'b0;
    active   = |s_q.sd_grp;
    for (int g = 0; g < 4; g++)
    begin
      clr_v[g] = 8'h00;
      if (i_bus.wr && (i_bus.addr == `PIA_ADDR_CLEAR1 + 6'(g)))
      begin
        clr_v[g] = i_bus.wdata;
      end
      clr_any  = clr_any | (|clr_v[g]);
      active   = active | (|(s_q.pend[g] & ~s_q.mask[g]));
      // hardware set wins over a clear in the same cycle
      s_d.pend[g] = ((s_q.pend[g] & ~clr_v[g]) | set_v[g]) & VALID[g];
      if (i_bus.wr && (i_bus.addr == `PIA_ADDR_MASK1 + 6'(g)))
      begin
        s_d.mask[g] = i_bus.wdata & VALID[g];
      end
    end
    // dummy bit of the pin monitor group is writable
    if (i_bus.wr && (i_bus.addr == `PIA_ADDR_GROUP4))
    begin
      s_d.pend[3][`PIA_DUMMY_BIT] = i_bus.wdata[`PIA_DUMMY_BIT];
    end
    // group self-test failures clear with any clear of their group
    for (int g = 0; g < 2; g++)
    begin
      s_d.sd_grp[g] = (s_q.sd_grp[g] & ~(|clr_v[g])) | sd_lvl[g];
    end
    // hold-off timer restarts on every clear
    if (clr_any)
    begin
      s_d.hold_cnt = HOLD_LOAD;
    end
    else if (s_q.hold_cnt != 16'h0000)
    begin
      s_d.hold_cnt = s_q.hold_cnt - 16'h0001;
    end
    s_d.irq_n = ~(active && (s_q.hold_cnt == 16'h0000) && !clr_any);
    // summary, built only from pending state
    s_d.summary = 8'h00;
    s_d.summary[0] = (|s_q.pend[0]) | s_q.sd_grp[0];
    s_d.summary[1] = (|s_q.pend[1]) | s_q.sd_grp[1];
    s_d.summary[2] = |s_q.pend[2];
    s_d.summary[3] = |s_q.pend[3];
    s_d.summary[`PIA_SUM_SELFTEST] = (|s_q.sd_grp) |
                                     (|(s_q.pend[2] & `PIA_SELFTEST_MISC));
    for (int g = 0; g < 4; g++)
    begin
      s_d.summary[`PIA_SUM_RESET] = s_d.summary[`PIA_SUM_RESET] |
                                    (|(s_q.pend[g] & RSTC[g]));
    end
    // read data stands for one cycle only
    s_d.rdata = 8'h00;
    if (i_bus.rd)
    begin
      if (i_bus.addr == `PIA_ADDR_SUMMARY)
      begin
        s_d.rdata = s_q.summary;
      end
      else if ((i_bus.addr >= `PIA_ADDR_GROUP1) && (i_bus.addr <= `PIA_ADDR_GROUP4))
      begin
        s_d.rdata = s_q.pend[2'(i_bus.addr - `PIA_ADDR_GROUP1)];
      end
      else if ((i_bus.addr >= `PIA_ADDR_MASK1) && (i_bus.addr <= `PIA_ADDR_MASK4))
      begin
        s_d.rdata = s_q.mask[2'(i_bus.addr - `PIA_ADDR_MASK1)];
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q          <= '0;
      s_q.pend     <= {4{`PIA_RST_PEND}};
      s_q.mask     <= {4{`PIA_RST_MASK}};
      s_q.irq_n    <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs from flip-flops
  assign o_irq_out_n          = s_q.irq_n;
  assign o_irq_source_summary = s_q.summary;
  assign o_rdata              = s_q.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_clk);
  endclocking

  default disable iff (!rst_n);

  logic wr_clr1;
  assign wr_clr1 = i_bus.wr && (i_bus.addr == `PIA_ADDR_CLEAR1);

  a_irq_asserts_low:
    assert property (active && (s_q.hold_cnt == 16'h0000) && !clr_any |=> !o_irq_out_n)
    else $error("interrupt not low with unmasked factor pending");

  a_mask_blocks_irq:
    assert property (!active |=> o_irq_out_n)
    else $error("interrupt low without any unmasked factor");

  a_holdoff_keeps_high:
    assert property (clr_any |=> o_irq_out_n [*8])
    else $error("interrupt low inside hold-off window");

  a_holdoff_length:
    assert property (clr_any |=> (s_q.hold_cnt == HOLD_LOAD))
    else $error("hold-off timer not loaded with full count");

  a_group_summary:
    assert property (##1 o_irq_source_summary[3:2] ==
                     {|$past(s_q.pend[3]), |$past(s_q.pend[2])})
    else $error("group summary bits disagree with pending groups");

  a_selftest_summary:
    assert property ($rose(sd_lvl[0]) |-> ##2 (o_irq_source_summary[0] &&
                     o_irq_source_summary[`PIA_SUM_SELFTEST]))
    else $error("self-test failure not shown in group and self-test bits");

  a_mismatch_flag:
    assert property (mismatch[0] |-> ##2 o_irq_source_summary[3])
    else $error("pin mismatch not shown in summary");

  a_reset_summary:
    assert property (##1 o_irq_source_summary[`PIA_SUM_RESET] ==
                     ($past(s_q.pend[0][4]) | (|$past(s_q.pend[1][5:4])) |
                      $past(s_q.pend[2][5])))
    else $error("reset cause bit disagrees with pending factors");

  a_summary_no_direct:
    assert property ($fell(o_irq_source_summary[2]) |->
                     $past(i_bus.wr && (i_bus.addr == `PIA_ADDR_CLEAR1 + 6'h02), 2))
    else $error("summary bit dropped without a clear of its factors");

  a_clear_one_bit:
    assert property (wr_clr1 && i_bus.wdata[0] && !uv_lvl[0] |=> !s_q.pend[0][0])
    else $error("write of one did not clear the flag");

  a_release_high:
    assert property (wr_clr1 && (i_bus.wdata != 8'h00) && (i_bus.wdata == s_q.pend[0]) |=>
                     o_irq_out_n)
    else $error("interrupt not released after group cleared");

  a_group_read:
    assert property (i_bus.rd && (i_bus.addr == `PIA_ADDR_GROUP1) |=>
                     (o_rdata == $past(s_q.pend[0])))
    else $error("group read data wrong");

  a_flag_latched:
    assert property (s_q.pend[0][0] && !(wr_clr1 && i_bus.wdata[0]) |=> s_q.pend[0][0])
    else $error("pending flag dropped without a clear");

  a_holdoff_high:
    assert property ((s_q.hold_cnt != 16'h0000) |=> o_irq_out_n)
    else $error("interrupt low while hold-off timer runs");

  a_holdoff_count:
    assert property ((s_q.hold_cnt != 16'h0000) && !clr_any |=>
                     (s_q.hold_cnt == $past(s_q.hold_cnt) - 16'h0001))
    else $error("hold-off timer did not count down");

  a_low_group_summary:
    assert property (##1 o_irq_source_summary[1:0] ==
                     {(|$past(s_q.pend[1])) | $past(s_q.sd_grp[1]),
                      (|$past(s_q.pend[0])) | $past(s_q.sd_grp[0])})
    else $error("low group summary bits disagree with pending groups");

  a_selftest_bit:
    assert property (##1 o_irq_source_summary[`PIA_SUM_SELFTEST] ==
                     ((|$past(s_q.sd_grp)) | (|($past(s_q.pend[2]) & `PIA_SELFTEST_MISC))))
    else $error("self-test summary bit disagrees with self-test factors");

  a_masked_latch:
    assert property (uv_lvl[0] |=> s_q.pend[0][0])
    else $error("detected factor not latched");

  a_group_write_ignored:
    assert property (i_bus.wr && (i_bus.addr == `PIA_ADDR_GROUP1) && !(|uv_lvl) |=>
                     (s_q.pend[0] == $past(s_q.pend[0])))
    else $error("write changed a read-only request group");

  a_dummy_write:
    assert property (i_bus.wr && (i_bus.addr == `PIA_ADDR_GROUP4) |=>
                     (s_q.pend[3][`PIA_DUMMY_BIT] == $past(i_bus.wdata[`PIA_DUMMY_BIT])))
    else $error("dummy bit did not take the written value");

  a_rdata_idle:
    assert property (!i_bus.rd |=> (o_rdata == 8'h00))
    else $error("read data not zero outside a read");

  a_summary_read:
    assert property (i_bus.rd && (i_bus.addr == `PIA_ADDR_SUMMARY) |=>
                     (o_rdata == $past(o_irq_source_summary)))
    else $error("summary read data wrong");

  a_mask_read:
    assert property (i_bus.rd && (i_bus.addr == `PIA_ADDR_MASK1 + 6'h02) |=>
                     (o_rdata == $past(s_q.mask[2])))
    else $error("mask read data wrong");

  c_irq_low:
    cover property (o_irq_out_n ##1 !o_irq_out_n);

  c_clear_release:
    cover property (!o_irq_out_n ##0 clr_any ##1 o_irq_out_n);

  c_holdoff_end:
    cover property ((s_q.hold_cnt == 16'h0001) && active ##2 !o_irq_out_n);

  c_mismatch:
    cover property (|mismatch);

  c_selftest:
    cover property ($rose(o_irq_source_summary[`PIA_SUM_SELFTEST]));

endmodule : pia_top

// ### verification/pia_host_model.sv
// host side model: counts interrupt assertions seen on the interrupt pin
`timescale 1ns/1ns

module pia_host_model (
  // clock and pin
  input  wire logic i_clk,
  input  wire logic i_irq_out_n,
  // interrupts taken so far
  output int        o_irq_count
);
  logic prev_q;

  // falling edge of the active-low pin counts one interrupt
  initial o_irq_count = 0;
  initial prev_q = 1'b1;
  always @(posedge i_clk)
  begin
    if (prev_q === 1'b1 && i_irq_out_n === 1'b0)
      o_irq_count <= o_irq_count + 1;
    prev_q <= i_irq_out_n;
  end
endmodule : pia_host_model

// ### verification/tb_top.sv
// self-checking testbench of the pmic interrupt aggregator
`timescale 1ns/1ns

module tb_top;
  localparam int HOLD = 20;
  logic                  clk;
  logic                  nrst;
  pia_pkg::pia_bus_req_t bus;
  logic [7:0]            rdata, summary, uv, misc;
  logic [5:0]            ov;
  logic [1:0]            sd;
  logic [4:0]            cmd, mon;
  logic                  irq_n;
  int                    irq_seen, n_errors, check_count;

  pia_top #(.HOLDOFF_CYC(HOLD)) dut (.i_clk(clk), .i_nrst(nrst), .i_bus(bus),
    .o_rdata(rdata), .i_undervolt_det(uv), .i_overvolt_det(ov), .i_misc_det(misc),
    .i_selftest_grp(sd), .i_pin_cmd(cmd), .i_pin_mon(mon), .o_irq_out_n(irq_n),
    .o_irq_source_summary(summary));
  pia_host_model host (.i_clk(clk), .i_irq_out_n(irq_n), .o_irq_count(irq_seen));

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic rchk(input string what, input logic [5:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(what, exp, rdata);
  endtask : rchk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic wait_irq(input logic lvl, input int max);
    int i;
    i = 0;
    while (irq_n !== lvl && i < max)
    begin
      @(posedge clk);
      #1 i++;
    end
    check("irq pin", {7'h00, lvl}, {7'h00, irq_n});
  endtask : wait_irq

  // detector pulse long enough to pass the pin filter
  task automatic pulse(input int g, input logic [7:0] b);
    @(posedge clk);
    case (g)
      0: uv <= b;
      1: ov <= b[5:0];
      default: misc <= b;
    endcase
    cyc(6);
    uv <= 8'h00;
    ov <= 6'h00;
    misc <= 8'h00;
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check("irq after reset", 8'h01, {7'h00, irq_n});
    rchk("summary reset", 6'h03, 8'h00);
    for (int a = 4; a < 8; a++)
      rchk("group reset", a[5:0], 8'h00);
    rchk("unmapped", 6'h20, 8'h00);
    rchk("clear reg read", 6'h08, 8'h00);
    wr(6'h03, 8'hFF);
    rchk("summary write", 6'h03, 8'h00);
    wr(6'h04, 8'hFF);
    rchk("group write", 6'h04, 8'h00);
    wr(6'h07, 8'h80);
    rchk("dummy bit", 6'h07, 8'h80);
    wait_irq(1'b0, 4);
    wr(6'h0B, 8'h80);
    rchk("dummy cleared", 6'h07, 8'h00);
    cyc(HOLD + 5);
    $display("test reset done");
  endtask : t_reset

  task automatic t_groups();
    logic [7:0] b[3] = '{8'h10, 8'h20, 8'h80};
    logic [7:0] s[3] = '{8'h21, 8'h22, 8'h04};
    for (int g = 0; g < 3; g++)
    begin
      pulse(g, b[g]);
      wait_irq(1'b0, 10);
      cyc(3);
      rchk("group flag", 6'h04 + g[5:0], b[g]);
      rchk("summary", 6'h03, s[g]);
      check("summary pins", s[g], summary);
      wr(6'h08 + g[5:0], ~b[g]);
      cyc(2);
      rchk("zero clear", 6'h04 + g[5:0], b[g]);
      wr(6'h08 + g[5:0], b[g]);
      cyc(3);
      check("irq released", 8'h01, {7'h00, irq_n});
      rchk("group cleared", 6'h04 + g[5:0], 8'h00);
      rchk("summary cleared", 6'h03, 8'h00);
      check("summary pins cleared", 8'h00, summary);
      cyc(HOLD + 5);
      check("irq stays high", 8'h01, {7'h00, irq_n});
    end
    $display("test groups done");
  endtask : t_groups

  task automatic t_holdoff();
    int lows, c0;
    lows = 0;
    c0 = irq_seen;
    pulse(0, 8'h01);
    wait_irq(1'b0, 10);
    cyc(4);
    wr(6'h08, 8'h01);
    pulse(1, 8'h01);
    repeat (HOLD - 7)
    begin
      @(posedge clk);
      #1 if (irq_n !== 1'b1) lows++;
    end
    check("low in hold-off", 8'h00, lows[7:0]);
    wait_irq(1'b0, 3);
    cyc(2);
    check("interrupts seen", 8'h02, 8'(irq_seen - c0));
    wr(6'h09, 8'h01);
    cyc(HOLD + 5);
    $display("test holdoff done");
  endtask : t_holdoff

  task automatic t_mask();
    wr(6'h0E, 8'h02);
    rchk("mask read", 6'h0E, 8'h02);
    pulse(2, 8'h02);
    cyc(6);
    check("masked irq", 8'h01, {7'h00, irq_n});
    rchk("masked flag", 6'h06, 8'h02);
    wr(6'h0A, 8'h02);
    wr(6'h0E, 8'h00);
    cyc(HOLD + 5);
    $display("test mask done");
  endtask : t_mask

  task automatic t_selftest();
    for (int g = 0; g < 2; g++)
    begin
      @(posedge clk);
      sd <= 2'b01 << g;
      wait_irq(1'b0, 10);
      cyc(2);
      rchk("selftest summary", 6'h03, 8'h10 | (8'h01 << g));
      sd <= 2'b00;
      cyc(6);
      wr(6'h08 + g[5:0], 8'hFF);
      cyc(3);
      rchk("selftest cleared", 6'h03, 8'h00);
      cyc(HOLD + 5);
    end
    $display("test selftest done");
  endtask : t_selftest

  task automatic t_pins();
    for (int p = 0; p < 5; p++)
    begin
      @(posedge clk);
      mon <= cmd ^ (5'h01 << p);
      cyc(10);
      mon <= cmd;
      wait_irq(1'b0, 10);
      cyc(2);
      rchk("pin flag", 6'h07, 8'h01 << p);
      rchk("pin summary", 6'h03, 8'h08);
      wr(6'h0B, 8'h01 << p);
      cyc(HOLD + 5);
    end
    $display("test pins done");
  endtask : t_pins

  ////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // main sequence
  initial
  begin
    nrst = 1'b0;
    bus = '0;
    uv = 8'h00;
    ov = 6'h00;
    misc = 8'h00;
    sd = 2'b00;
    cmd = 5'h15;
    mon = 5'h15;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    cyc(8);
    t_reset();
    t_groups();
    t_holdoff();
    t_mask();
    t_selftest();
    t_pins();
    conclude();
  end

  // watchdog against a hang
  initial
  begin
    repeat (8000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule : tb_top
